/* status_pkg.sv */
package status_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] RES_CODE_OFFSET   = 8'h0c;
  localparam logic [7:0] LINK_ERR_OFFSET   = 8'h0d;
  localparam logic [7:0] SHORT_FLAGS_OFFSET = 8'h0e;
  localparam int         REG_WIDTH         = 13;

  // ==========================================================
  // Field positions
  localparam int FIRST_CODE_LSB   = 0;
  localparam int SECOND_CODE_LSB  = 4;
  localparam int THIRD_CODE_LSB   = 8;
  localparam int CODE_WIDTH       = 4;
  localparam int ID_HIGH_LSB      = 4;
  localparam int PAYLOAD_START_BIT = 1;
  localparam int PAYLOAD_STOP_BIT = 2;
  localparam int SYNC_STOP_BIT    = 3;
  localparam int PAYLOAD_PAR_BIT  = 4;
  localparam int SYNC_PAR_BIT     = 5;
  localparam int CRC_ERR_BIT      = 6;
  localparam int TIMEOUT_BIT      = 7;
  localparam int WATCHDOG_BIT     = 8;
  localparam int NUM_SWITCHES     = 6;
  localparam int SUMMARY_LINK_BIT = 6;
  localparam int SUMMARY_SHORT_BIT = 3;

  // ==========================================================
  // Reset values
  localparam logic [8:1] LINK_ERR_RESET  = 8'h00;
  localparam logic [5:0] SHORT_RESET     = 6'h00;
  localparam logic [11:0] CODES_RESET    = 12'h000;

  // ==========================================================
  // Timing
  localparam longint unsigned CLK_HZ        = 64'h0000_0000_0beb_c200;
  localparam longint unsigned WD_TIME_S     = 64'h0000_0000_0000_0004;
  localparam int unsigned     WD_CYCLES     = 32'(WD_TIME_S * CLK_HZ);
  localparam int              WD_CNT_WIDTH  = 30;
  localparam int              BIT_LEN_WIDTH = 16;
  localparam int              TIMEOUT_BITS  = 16;
  localparam int              IDLE_WIDTH    = 21;

  // Receive error events, one-cycle pulses from the framing logic
  typedef struct packed {
    logic crc_fail;
    logic sync_parity;
    logic payload_parity;
    logic sync_stop;
    logic payload_stop;
    logic payload_start;
  } rx_err_type;

  // Register access request
  typedef struct packed {
    logic            wr;
    logic            rd;
    logic [7:0]      addr;
    logic [12:0]     wdata;
  } reg_req_type;

endpackage

/* status_regs.sv */
// Function
// - Capture each address resistor's 4-bit code once at power-up.
// - Codes read at 11:8, 7:4, 3:0, read-only.
// - Bits 5:4 form device identity upper two bits.
// - First resistor code forms identity low four bits.
// - Watchdog flag bit 8 sets after 4 s receive inactivity.
// - Timeout flag bit 7 sets after over 16 idle bit lengths mid-packet.
// - Bit length re-measured from each packet's sync frame.
// - Reject failed-CRC transactions; set CRC flag bit 6.
// - Sync frame parity error sets bit 5.
// - Payload parity error sets bit 4.
// - Sync frame bad stop bit sets bit 3.
// - Payload frame bad stop bit sets bit 2.
// - Payload frame bad start bit sets bit 1.
// - Link flags reset to zero, cleared by writing one.
// - Clearing settled as write-one-to-clear only; reads do not clear.
// - Six short flags in bits 5:0, reset zero, write-one-to-clear.
// - Short summary high while any short flag set.
// - Link error summary high while any link flag set.
`timescale 1ns/10ps
`default_nettype none

module status_regs #(
  parameter int unsigned WD_CYCLES = status_pkg::WD_CYCLES
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  input  wire status_pkg::reg_req_type  reg_req,
  output logic [12:0]                   reg_rdata,
  output logic                          reg_rvalid,
  input  wire logic                     codes_done,
  input  wire logic [11:0]              measured_codes,
  input  wire logic                     rx_line,
  input  wire logic                     rx_in_packet,
  input  wire logic                     sync_done,
  input  wire logic [15:0]              sync_bit_cycles,
  input  wire status_pkg::rx_err_type   rx_err,
  input  wire logic [5:0]               short_detect,
  output logic [5:0]                    device_id,
  output logic                          txn_reject,
  output logic                          any_short_summary,
  output logic                          link_err_summary
);

  // ==========================================================
  // State
  logic [11:0] codes;
  logic        codes_held;
  logic [8:1]  link_flags;
  logic [5:0]  per_switch_short_flags;
  logic        rx_prev;
  logic [status_pkg::WD_CNT_WIDTH-1:0]  wd_cnt;
  logic [status_pkg::BIT_LEN_WIDTH-1:0] bit_len;
  logic [status_pkg::IDLE_WIDTH-1:0]    idle_cnt;

  logic [11:0] next_codes;
  logic        next_codes_held;
  logic [8:1]  next_link_flags;
  logic [5:0]  next_short_flags;
  logic [status_pkg::WD_CNT_WIDTH-1:0]  next_wd_cnt;
  logic [status_pkg::BIT_LEN_WIDTH-1:0] next_bit_len;
  logic [status_pkg::IDLE_WIDTH-1:0]    next_idle_cnt;
  logic [12:0] next_rdata;
  logic [5:0]  next_device_id;
  logic        next_rvalid;
  logic        next_txn_reject;
  logic        next_any_short;
  logic        next_link_summary;

  logic [8:1]  link_set;
  logic [8:1]  link_clr;
  logic [5:0]  short_clr;
  logic        rx_edge;
  logic        wd_expire;
  logic        timeout_hit;
  logic [status_pkg::IDLE_WIDTH-1:0] idle_limit;
  logic        wr_link;
  logic        wr_short;

  // ==========================================================
  // Activity detection and timers
  always_comb begin
    rx_edge    = rx_line ^ rx_prev;
    idle_limit = status_pkg::IDLE_WIDTH'(bit_len) * status_pkg::IDLE_WIDTH'(status_pkg::TIMEOUT_BITS);
    wd_expire  = (wd_cnt == status_pkg::WD_CNT_WIDTH'(WD_CYCLES - 1)) && !rx_edge;
    // Bit length refreshed on every sync frame
    next_bit_len = sync_done ? sync_bit_cycles : bit_len;
    // Watchdog counts idle cycles, restarts on any edge, saturates
    if (rx_edge) begin
      next_wd_cnt = '0;
    end else if (wd_cnt != status_pkg::WD_CNT_WIDTH'(WD_CYCLES)) begin
      next_wd_cnt = wd_cnt + 1'b1;
    end else begin
      next_wd_cnt = wd_cnt;
    end
    // Idle count within a packet, restarted by edges and new sync
    timeout_hit = rx_in_packet && !rx_edge && !sync_done && (idle_cnt == idle_limit);
    if (!rx_in_packet || rx_edge || sync_done) begin
      next_idle_cnt = '0;
    end else if (idle_cnt <= idle_limit) begin
      next_idle_cnt = idle_cnt + 1'b1;
    end else begin
      next_idle_cnt = idle_cnt;
    end
  end

  // ==========================================================
  // Sticky flags, set beats clear
  always_comb begin
    wr_link  = reg_req.wr && (reg_req.addr == status_pkg::LINK_ERR_OFFSET);
    wr_short = reg_req.wr && (reg_req.addr == status_pkg::SHORT_FLAGS_OFFSET);
    link_clr  = wr_link ? reg_req.wdata[8:1] : 8'h00;
    short_clr = wr_short ? reg_req.wdata[5:0] : 6'h00;
    link_set = 8'h00;
    link_set[status_pkg::WATCHDOG_BIT]      = wd_expire;
    link_set[status_pkg::TIMEOUT_BIT]       = timeout_hit;
    link_set[status_pkg::CRC_ERR_BIT]       = rx_err.crc_fail;
    link_set[status_pkg::SYNC_PAR_BIT]      = rx_err.sync_parity;
    link_set[status_pkg::PAYLOAD_PAR_BIT]   = rx_err.payload_parity;
    link_set[status_pkg::SYNC_STOP_BIT]     = rx_err.sync_stop;
    link_set[status_pkg::PAYLOAD_STOP_BIT]  = rx_err.payload_stop;
    link_set[status_pkg::PAYLOAD_START_BIT] = rx_err.payload_start;
    next_link_flags  = (link_flags & ~link_clr) | link_set;
    // Summaries follow the next flag values, so they move with the flags; reject is crc_fail registered, a one-cycle pulse
    next_link_summary = |next_link_flags;
    next_any_short    = |next_short_flags;
    next_txn_reject   = rx_err.crc_fail;
    next_rvalid       = reg_req.rd;
    // Codes captured on the first measurement only
    next_codes      = (codes_done && !codes_held) ? measured_codes : codes;
    next_codes_held = codes_held | codes_done;
    next_device_id  = {next_codes[status_pkg::ID_HIGH_LSB +: 2],
                       next_codes[status_pkg::FIRST_CODE_LSB +: 4]};
  end

  // ==========================================================
  // Per-switch short flags, a new detect beats a same-cycle clear
  for (genvar sw = 0; sw < status_pkg::NUM_SWITCHES; sw++) begin : gen_switch
    assign next_short_flags[sw] = (per_switch_short_flags[sw] & ~short_clr[sw])
                                  | short_detect[sw];

    // Each switch flag holds until its own clear bit is written
    chk_switch_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (per_switch_short_flags[sw] && !short_clr[sw]) |=> per_switch_short_flags[sw])
      else $error("Short flag dropped without clear");
  end

  // ==========================================================
  // Read mux, unmapped reads return zero, reads never clear
  // The last read data stays on reg_rdata until the next read
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_req.rd) begin
      case (reg_req.addr)
        status_pkg::RES_CODE_OFFSET:    next_rdata = {1'b0, codes};
        status_pkg::LINK_ERR_OFFSET:    next_rdata = {4'h0, link_flags, 1'b0};
        status_pkg::SHORT_FLAGS_OFFSET: next_rdata = {7'h00, per_switch_short_flags};
        default:                        next_rdata = 13'h0000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      codes                  <= status_pkg::CODES_RESET;
      codes_held             <= 1'b0;
      link_flags             <= status_pkg::LINK_ERR_RESET;
      per_switch_short_flags <= status_pkg::SHORT_RESET;
      rx_prev                <= 1'b1;
      wd_cnt                 <= '0;
      bit_len                <= '0;
      idle_cnt               <= '0;
      reg_rdata              <= 13'h0000;
      reg_rvalid             <= 1'b0;
      device_id              <= 6'h00;
      txn_reject             <= 1'b0;
      any_short_summary      <= 1'b0;
      link_err_summary       <= 1'b0;
    end else begin
      codes                  <= next_codes;
      codes_held             <= next_codes_held;
      link_flags             <= next_link_flags;
      per_switch_short_flags <= next_short_flags;
      rx_prev                <= rx_line;
      wd_cnt                 <= next_wd_cnt;
      bit_len                <= next_bit_len;
      idle_cnt               <= next_idle_cnt;
      reg_rdata              <= next_rdata;
      reg_rvalid             <= next_rvalid;
      device_id              <= next_device_id;
      txn_reject             <= next_txn_reject;
      any_short_summary      <= next_any_short;
      link_err_summary       <= next_link_summary;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_link_set_wins: assert property (
    rx_err.payload_parity |=> link_flags[status_pkg::PAYLOAD_PAR_BIT])
    else $error("Payload parity flag missed");

  chk_link_w1c: assert property (
    (wr_link && reg_req.wdata[5] && !rx_err.sync_parity) |=> !link_flags[5])
    else $error("Sync parity flag not cleared");

  chk_flag_sticky: assert property (
    (link_flags[6] && !(wr_link && reg_req.wdata[6])) |=> link_flags[6])
    else $error("CRC flag dropped without clear");

  chk_read_no_clear: assert property (
    (reg_req.rd && !reg_req.wr && link_flags[3]) |=> link_flags[3])
    else $error("Read cleared a link flag");

  chk_short_sets: assert property (
    short_detect[2] |=> per_switch_short_flags[2] && any_short_summary)
    else $error("Short flag or summary missed");

  chk_short_summary: assert property (
    any_short_summary == (per_switch_short_flags != 6'h00))
    else $error("Short summary wrong");

  chk_link_summary: assert property (
    link_err_summary == (link_flags != 8'h00))
    else $error("Link summary wrong");

  chk_codes_once: assert property (
    codes_held |=> $stable(codes))
    else $error("Resistor codes changed after capture");

  chk_device_id: assert property (
    device_id == {codes[5:4], codes[3:0]})
    else $error("Device identity mismatch");

  chk_read_codes: assert property (
    (reg_req.rd && reg_req.addr == status_pkg::RES_CODE_OFFSET) |=>
      reg_rvalid && reg_rdata == {1'b0, $past(codes)})
    else $error("Code read wrong");

  chk_crc_reject: assert property (
    rx_err.crc_fail |=> txn_reject ##0 link_flags[6])
    else $error("CRC reject missing");

  chk_watchdog_flag: assert property (
    wd_expire |=> link_flags[8])
    else $error("Watchdog flag missed");

  chk_timeout_flag: assert property (
    timeout_hit |=> link_flags[7] ##0 idle_cnt > idle_limit)
    else $error("Timeout flag missed");

  chk_sync_stop_set: assert property (
    rx_err.sync_stop |=> link_flags[status_pkg::SYNC_STOP_BIT])
    else $error("Sync stop flag missed");

  // Register access, capture and timer restarts
  chk_rvalid_pulse: assert property (
    !reg_req.rd |=> !reg_rvalid)
    else $error("Read valid without a read");

  chk_codes_capture: assert property (
    (codes_done && !codes_held) |=> codes == $past(measured_codes))
    else $error("Resistor codes not captured");

  chk_codes_read_only: assert property (
    (reg_req.wr && reg_req.addr == status_pkg::RES_CODE_OFFSET && codes_held) |=>
      $stable(codes))
    else $error("Write changed resistor codes");

  chk_read_link: assert property (
    (reg_req.rd && reg_req.addr == status_pkg::LINK_ERR_OFFSET) |=>
      reg_rdata == {4'h0, $past(link_flags), 1'b0})
    else $error("Link status read wrong");

  chk_read_short: assert property (
    (reg_req.rd && reg_req.addr == status_pkg::SHORT_FLAGS_OFFSET) |=>
      reg_rdata == {7'h00, $past(per_switch_short_flags)})
    else $error("Short status read wrong");

  chk_short_w1c: assert property (
    (wr_short && reg_req.wdata[0] && !short_detect[0]) |=> !per_switch_short_flags[0])
    else $error("Short flag not cleared");

  chk_reject_pulse: assert property (
    !rx_err.crc_fail |=> !txn_reject)
    else $error("Reject without CRC failure");

  chk_bit_len_sync: assert property (
    sync_done |=> bit_len == $past(sync_bit_cycles))
    else $error("Bit length not refreshed");

  chk_idle_restart: assert property (
    (rx_edge || sync_done) |=> (idle_cnt == '0))
    else $error("Idle count not restarted");

  chk_wd_restart: assert property (
    rx_edge |=> (wd_cnt == '0))
    else $error("Watchdog count not restarted");

  cov_crc: cover property (rx_err.crc_fail ##1 wr_link ##1 !link_flags[6]);
  cov_timeout: cover property (sync_done ##[1:300] timeout_hit);
  cov_short_clear: cover property (short_detect[0] ##[1:20] wr_short);
  cov_watchdog: cover property (wd_expire);
  cov_codes_capture: cover property (codes_done ##1 codes_held);

endmodule

`default_nettype wire

/* uart_rx_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Receive framing model facing the status block
module uart_rx_model (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic                   pkt_active,
  input  wire logic                   line_quiet,
  input  wire logic                   sync_req,
  input  wire logic [15:0]            bit_len,
  input  wire status_pkg::rx_err_type err_req,
  output var  logic                   rx_line,
  output var  logic                   rx_in_packet,
  output var  logic                   sync_done,
  output var  logic [15:0]            sync_bit_cycles,
  output var  status_pkg::rx_err_type rx_err
);
  logic next_rx_line;
  // Toggles each cycle while traffic flows, rests high when quiet
  always_comb begin
    next_rx_line = line_quiet ? 1'b1 : ~rx_line;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_line <= 1'b1;
    end else begin
      rx_line <= next_rx_line;
    end
  end
  // Framer results, bit length measured per sync frame
  assign rx_in_packet    = pkt_active;
  assign sync_done       = sync_req;
  assign sync_bit_cycles = bit_len;
  assign rx_err          = err_req;
endmodule
`default_nettype wire

/* status_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
module status_regs_test;
  logic                    ref_clk = 1'b0;
  logic                    rst_b = 1'b0;
  status_pkg::reg_req_type reg_req = '0;
  logic [12:0]             reg_rdata;
  logic                    reg_rvalid, codes_done = 1'b0;
  logic [11:0]             measured_codes = 12'h000;
  logic [5:0]              short_detect = 6'h00, device_id;
  logic                    txn_reject, any_short_summary, link_err_summary;
  logic                    rx_line, rx_in_packet, sync_done;
  logic                    pkt_active = 1'b0, line_quiet = 1'b0, sync_req = 1'b0;
  logic [15:0]             sync_bit_cycles, bit_len = 16'h0000;
  status_pkg::rx_err_type  rx_err, err_req = '0;
  int                      failures = 0, checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  // ==========================================================
  // Design and far-side model
  status_regs #(.WD_CYCLES(50)) status_regs_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .codes_done(codes_done), .measured_codes(measured_codes), .rx_line(rx_line),
    .rx_in_packet(rx_in_packet), .sync_done(sync_done), .sync_bit_cycles(sync_bit_cycles),
    .rx_err(rx_err), .short_detect(short_detect), .device_id(device_id),
    .txn_reject(txn_reject), .any_short_summary(any_short_summary),
    .link_err_summary(link_err_summary));
  uart_rx_model uart_rx_model_i (.ref_clk(ref_clk), .rst_b(rst_b), .pkt_active(pkt_active),
    .line_quiet(line_quiet), .sync_req(sync_req), .bit_len(bit_len), .err_req(err_req),
    .rx_line(rx_line), .rx_in_packet(rx_in_packet), .sync_done(sync_done),
    .sync_bit_cycles(sync_bit_cycles), .rx_err(rx_err));

  // ==========================================================
  // Access tasks
  task automatic check(input string name, input logic [12:0] exp, input logic [12:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [12:0] d);
    @(posedge ref_clk);
    reg_req.wr <= 1'b1;
    reg_req.addr <= a;
    reg_req.wdata <= d;
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [12:0] exp, input string name);
    int n;
    @(posedge ref_clk);
    reg_req.rd <= 1'b1;
    reg_req.addr <= a;
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 4);
    check("read_valid", 13'h0001, {12'h000, reg_rvalid});
    check(name, exp, reg_rdata);
  endtask
  task automatic quiet_pkt(input logic [15:0] len);
    @(posedge ref_clk);
    pkt_active <= 1'b1;
    sync_req <= 1'b1;
    bit_len <= len;
    line_quiet <= 1'b1;
    @(posedge ref_clk);
    sync_req <= 1'b0;
  endtask
  task automatic end_pkt;
    @(posedge ref_clk);
    pkt_active <= 1'b0;
    line_quiet <= 1'b0;
    reg_write(8'h0d, 13'h0080);
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    finish_test();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    reg_read(8'h0d, 13'h0000, "link_reset");
    reg_read(8'h0e, 13'h0000, "short_reset");
    reg_read(8'h0c, 13'h0000, "codes_reset");
    @(posedge ref_clk);
    codes_done <= 1'b1;
    measured_codes <= 12'h9b7;
    @(posedge ref_clk);
    codes_done <= 1'b0;
    @(posedge ref_clk);
    codes_done <= 1'b1;
    measured_codes <= 12'h426;
    @(posedge ref_clk);
    codes_done <= 1'b0;
    reg_write(8'h0c, 13'h1fff);
    reg_read(8'h0c, 13'h09b7, "codes");
    check("device_id", 13'h0037, {7'h00, device_id});
    // Each error sets its own bit, survives reads, clears by writing one
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      err_req <= status_pkg::rx_err_type'(6'h01 << i);
      @(posedge ref_clk);
      err_req <= '0;
      @(negedge ref_clk);
      check("txn_reject", 13'(i == 5), {12'h000, txn_reject});
      reg_read(8'h0d, 13'(2 << i), "link_flag");
      reg_read(8'h0d, 13'(2 << i), "link_reread");
      check("link_summary", 13'h0001, {12'h000, link_err_summary});
      reg_write(8'h0d, 13'(2 << i));
      reg_read(8'h0d, 13'h0000, "link_cleared");
      check("link_summary_off", 13'h0000, {12'h000, link_err_summary});
    end
    // New event beats a clear in the same cycle
    @(posedge ref_clk);
    err_req <= status_pkg::rx_err_type'(6'h20);
    reg_req.wr <= 1'b1;
    reg_req.addr <= 8'h0d;
    reg_req.wdata <= 13'h0040;
    @(posedge ref_clk);
    err_req <= '0;
    reg_req.wr <= 1'b0;
    reg_read(8'h0d, 13'h0040, "set_beats_clear");
    reg_write(8'h0d, 13'h0040);
    // Short flags, with an ignored write to an unmapped place
    @(posedge ref_clk);
    short_detect <= 6'h2d;
    @(posedge ref_clk);
    short_detect <= 6'h00;
    reg_write(8'h0f, 13'h1fff);
    reg_read(8'h0e, 13'h002d, "short_flags");
    check("short_summary", 13'h0001, {12'h000, any_short_summary});
    reg_write(8'h0e, 13'h0005);
    reg_read(8'h0e, 13'h0028, "short_partial");
    // A detect in the cycle of its own clear wins
    @(posedge ref_clk);
    short_detect <= 6'h01;
    reg_req.wr <= 1'b1;
    reg_req.addr <= 8'h0e;
    reg_req.wdata <= 13'h0001;
    @(posedge ref_clk);
    short_detect <= 6'h00;
    reg_req.wr <= 1'b0;
    reg_read(8'h0e, 13'h0029, "short_set_wins");
    reg_write(8'h0e, 13'h1fff);
    reg_read(8'h0e, 13'h0000, "short_cleared");
    check("short_summary_off", 13'h0000, {12'h000, any_short_summary});
    reg_read(8'h20, 13'h0000, "unmapped");
    // Timeout with bit length one, then two
    quiet_pkt(16'h0001);
    repeat (25) @(posedge ref_clk);
    reg_read(8'h0d, 13'h0080, "timeout_len1");
    end_pkt();
    quiet_pkt(16'h0002);
    repeat (18) @(posedge ref_clk);
    reg_read(8'h0d, 13'h0000, "timeout_len2_early");
    repeat (15) @(posedge ref_clk);
    reg_read(8'h0d, 13'h0080, "timeout_len2");
    end_pkt();
    // Inactivity outside packets
    @(posedge ref_clk);
    line_quiet <= 1'b1;
    repeat (40) @(posedge ref_clk);
    reg_read(8'h0d, 13'h0000, "watchdog_early");
    repeat (15) @(posedge ref_clk);
    reg_read(8'h0d, 13'h0100, "watchdog");
    // Mid-run reset clears the flags and re-arms code capture
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    reg_read(8'h0d, 13'h0000, "link_after_reset");
    check("summary_after_reset", 13'h0000, {12'h000, link_err_summary});
    @(posedge ref_clk);
    codes_done <= 1'b1;
    measured_codes <= 12'h426;
    @(posedge ref_clk);
    codes_done <= 1'b0;
    reg_read(8'h0c, 13'h0426, "codes_after_reset");
    check("device_id_after_reset", 13'h0026, {7'h00, device_id});
    finish_test();
  end
endmodule
`default_nettype wire
